/* File: hw/dhp_pkg.sv */
// shared constants, types and helpers for the display host port
package dhp_pkg;
  // ==========================================
  // strap codes and pixel-format codes
  localparam logic [2:0] MODE_BUS18 = 3'h0;
  localparam logic [2:0] MODE_BUS16 = 3'h2;
  localparam logic [2:0] MODE_BUS8 = 3'h3;
  localparam logic [2:0] MODE_SERIAL = 3'h5;
  localparam logic [2:0] FMT_3BIT = 3'h1;
  localparam logic [2:0] FMT_565 = 3'h5;
  localparam logic [2:0] FMT_666 = 3'h6;
  localparam logic [2:0] FMT_RESET = 3'h6;
  // ==========================================
  // command codes
  localparam logic [7:0] CMD_PIX_FMT = 8'h3a;
  localparam logic [7:0] CMD_MEM_WR = 8'h2c;
  localparam logic [7:0] CMD_MEM_CONT = 8'h3c;
  // ==========================================
  // widths and field positions
  localparam int BUS_W = 18;
  localparam int CMP_W = 6;
  localparam int R_LSB = 12;
  localparam int G_LSB = 6;
  localparam int R565_LSB = 11;
  localparam int G565_LSB = 5;
  localparam int W_HI_LSB = 10;
  localparam int W_LO_LSB = 2;
  localparam int FRAME_BITS = 9;
  localparam int CNT_W = 10;
  // ==========================================
  // timing, in ns, and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int T_SETUP_NS = 20;
  localparam int T_WR_LOW_NS = 50;
  localparam int T_HOLD_NS = 60;
  localparam int T_RD_LOW_NS = 150;
  localparam int T_SCL_HALF_NS = 60;
  localparam int T_RST_LOW_NS = 10000;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int SETUP_CYC = ns2cyc(T_SETUP_NS);
  localparam int WR_LOW_CYC = ns2cyc(T_WR_LOW_NS);
  localparam int HOLD_CYC = ns2cyc(T_HOLD_NS);
  localparam int RD_LOW_CYC = ns2cyc(T_RD_LOW_NS);
  localparam int SCL_HALF_CYC = ns2cyc(T_SCL_HALF_NS);
  localparam int RST_CYC = ns2cyc(T_RST_LOW_NS);
  // ==========================================
  // host sequencer states, gray along idle-setup-low-hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_LOW = 2'b11,
    ST_HOLD = 2'b10
  } dhp_hstate_t;
  // ==========================================
  // 5-6-5 word to 6-6-6 pixel, short colours padded with their msb
  function automatic logic [BUS_W-1:0] dhp_x565(input logic [15:0] w);
    logic [4:0] r;
    logic [4:0] b;
    r = w[R565_LSB +: 5];
    b = w[4:0];
    return {r, r[4], w[G565_LSB +: CMP_W], b, b[4]};
  endfunction
  // one bit per colour to a full-scale 6-6-6 pixel
  function automatic logic [BUS_W-1:0] dhp_x111(input logic [2:0] c);
    return {{CMP_W{c[2]}}, {CMP_W{c[1]}}, {CMP_W{c[0]}}};
  endfunction
endpackage

/* File: hw/dhp_bus_if.sv */
// pin bundle between host end and display end
`timescale 1ns/1ps
interface dhp_bus_if;
  import dhp_pkg::*;
  logic [2:0] interface_mode_straps;
  logic panel_reset_n;
  logic cs_n;
  logic dc;
  logic write_strobe_n;
  logic read_strobe_n;
  logic sda;
  logic [BUS_W-1:0] host_db_o;
  logic host_db_oe_n;
  logic [BUS_W-1:0] dev_db_o;
  logic dev_db_oe_n;
  // resolved data lines; idle lines read high
  wire [BUS_W-1:0] db = !host_db_oe_n ? host_db_o : (!dev_db_oe_n ? dev_db_o : '1);
  modport host (
    output interface_mode_straps, panel_reset_n, cs_n, dc, write_strobe_n,
    output read_strobe_n, sda, host_db_o, host_db_oe_n,
    input db
  );
  modport device (
    input interface_mode_straps, panel_reset_n, cs_n, dc, write_strobe_n,
    input read_strobe_n, sda, db,
    output dev_db_o, dev_db_oe_n
  );
endinterface

/* File: hw/dhp_display_end.sv */
// display end of the host port: pin sampling, serial deframing, pixel packing
`timescale 1ns/1ps
module dhp_display_end
  import dhp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  dhp_bus_if.device bus,
  input wire logic [BUS_W-1:0] rd_data,
  output logic rd_start,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic param_valid,
  output logic [7:0] param_byte,
  output logic pixel_valid,
  output logic [BUS_W-1:0] pixel_rgb,
  output logic [2:0] pixel_format,
  output logic [2:0] bus_mode
);
  // ==========================================
  // pin sampling
  localparam int I_SDA = BUS_W;
  localparam int I_RD = BUS_W + 1;
  localparam int I_WR = BUS_W + 2;
  localparam int I_DC = BUS_W + 3;
  localparam int I_CS = BUS_W + 4;
  localparam int I_RST = BUS_W + 5;
  localparam int I_MODE = BUS_W + 6;
  localparam int SV_W = BUS_W + 9;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  logic [SV_W-1:0] raw;
  logic [SV_W-1:0] s1_ff;
  logic [SV_W-1:0] s2_ff;
  logic [SV_W-1:0] s3_ff;
  logic [SV_W-1:0] lvl_ff;
  logic [SV_W-1:0] prv_ff;
  logic [SV_W-1:0] nxt_lvl;

  assign raw = {bus.interface_mode_straps, bus.panel_reset_n, bus.cs_n, bus.dc,
                bus.write_strobe_n, bus.read_strobe_n, bus.sda, bus.db};
  // a bit moves only once the second and third stage agree
  assign nxt_lvl = ((s2_ff ~^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & lvl_ff);

  // three-stage synchroniser plus filtered level and its previous value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      lvl_ff <= '1;
      prv_ff <= '1;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      prv_ff <= lvl_ff;
    end
  end

  logic cs_act;
  logic wr_rise;
  logic cs_rise;
  logic rst_pin;
  assign cs_act = !lvl_ff[I_CS];
  assign wr_rise = lvl_ff[I_WR] & !prv_ff[I_WR];
  assign cs_rise = lvl_ff[I_CS] & !prv_ff[I_CS];
  assign rst_pin = !lvl_ff[I_RST];

  // ==========================================
  // strap capture: after release and again during every reset pulse
  logic [1:0] boot_ff;
  logic [2:0] mode_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_ff <= '0;
      mode_ff <= MODE_BUS18;
    end else begin
      if (boot_ff != BOOT_DONE) begin
        boot_ff <= boot_ff + 2'h1;
      end
      if (boot_ff != BOOT_DONE || rst_pin) begin
        mode_ff <= lvl_ff[I_MODE +: 3];
      end
    end
  end

  logic serial;
  assign serial = (mode_ff == MODE_SERIAL);

  // ==========================================
  // serial deframer: 9 bits, first bit is command/data
  logic [7:0] sh_ff;
  logic [3:0] bit_ff;
  logic frame_done;
  assign frame_done = serial && cs_act && wr_rise && (bit_ff == 4'(FRAME_BITS - 1));

  // bit counter restarts whenever select is dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= '0;
      bit_ff <= '0;
    end else if (!cs_act || rst_pin) begin
      bit_ff <= '0;
    end else if (serial && wr_rise) begin
      sh_ff <= {sh_ff[6:0], lvl_ff[I_SDA]};
      bit_ff <= frame_done ? 4'h0 : bit_ff + 4'h1;
    end
  end

  // ==========================================
  // unified write event from either link
  logic ev;
  logic ev_dc;
  logic [BUS_W-1:0] ev_word;
  always_comb begin
    ev = 1'b0;
    ev_dc = 1'b0;
    ev_word = '0;
    if (serial) begin
      ev = frame_done;
      ev_dc = sh_ff[7];
      ev_word = {10'h0, sh_ff[6:0], lvl_ff[I_SDA]};
    end else if (cs_act && wr_rise && !rst_pin) begin
      ev = 1'b1;
      ev_dc = lvl_ff[I_DC];
      ev_word = lvl_ff[BUS_W-1:0];
    end
  end

  // ==========================================
  // command and parameter decoding
  logic [7:0] last_cmd_ff;
  logic [2:0] fmt_ff;
  logic pix_ev;
  assign pix_ev = ev && ev_dc && (last_cmd_ff == CMD_MEM_WR || last_cmd_ff == CMD_MEM_CONT);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_cmd_ff <= '0;
      fmt_ff <= FMT_RESET;
      cmd_valid <= 1'b0;
      cmd_code <= '0;
      param_valid <= 1'b0;
      param_byte <= '0;
    end else begin
      cmd_valid <= 1'b0;
      param_valid <= 1'b0;
      if (rst_pin) begin
        last_cmd_ff <= '0;
        fmt_ff <= FMT_RESET;
      end else if (ev && !ev_dc) begin
        cmd_valid <= 1'b1;
        cmd_code <= ev_word[7:0];
        last_cmd_ff <= ev_word[7:0];
      end else if (ev && !pix_ev) begin
        param_valid <= 1'b1;
        param_byte <= ev_word[7:0];
        if (last_cmd_ff == CMD_PIX_FMT) begin
          fmt_ff <= ev_word[2:0];
        end
      end
    end
  end

  // ==========================================
  // pixel packing; unsupported mode/format pairs are dropped
  logic [1:0] phase_ff;
  logic [2*CMP_W-1:0] hold_ff;
  logic [BUS_W-1:0] pend_ff;
  logic pend_vld_ff;
  logic [1:0] nxt_phase;
  logic [2*CMP_W-1:0] nxt_hold;
  logic [BUS_W-1:0] nxt_pend;
  logic nxt_pend_vld;
  logic emit;
  logic [BUS_W-1:0] emit_px;
  logic clr;
  logic [CMP_W-1:0] c_hi;
  logic [CMP_W-1:0] c_lo;
  assign clr = rst_pin || cs_rise || (ev && !ev_dc);
  assign c_hi = ev_word[W_HI_LSB +: CMP_W];
  assign c_lo = ev_word[W_LO_LSB +: CMP_W];

  always_comb begin
    nxt_phase = phase_ff;
    nxt_hold = hold_ff;
    nxt_pend = pend_ff;
    nxt_pend_vld = 1'b0;
    emit = 1'b0;
    emit_px = '0;
    if (clr) begin
      nxt_phase = '0;
    end else if (pix_ev) begin
      case (mode_ff)
        MODE_BUS18: begin
          if (fmt_ff == FMT_666) begin
            emit = 1'b1;
            emit_px = ev_word;
          end
        end
        MODE_BUS16: begin
          if (fmt_ff == FMT_565) begin
            emit = 1'b1;
            emit_px = dhp_x565(ev_word[15:0]);
          end else if (fmt_ff == FMT_666) begin
            case (phase_ff)
              2'h0: begin
                nxt_hold = {c_hi, c_lo};
                nxt_phase = 2'h1;
              end
              2'h1: begin
                emit = 1'b1;
                emit_px = {hold_ff, c_hi};
                nxt_hold = {c_lo, c_lo};
                nxt_phase = 2'h2;
              end
              default: begin
                emit = 1'b1;
                emit_px = {hold_ff[CMP_W +: CMP_W], c_hi, c_lo};
                nxt_phase = 2'h0;
              end
            endcase
          end
        end
        MODE_BUS8, MODE_SERIAL: begin
          if (fmt_ff == FMT_565 && !serial) begin
            if (phase_ff == 2'h0) begin
              nxt_hold = {4'h0, ev_word[7:0]};
              nxt_phase = 2'h1;
            end else begin
              emit = 1'b1;
              emit_px = dhp_x565({hold_ff[7:0], ev_word[7:0]});
              nxt_phase = 2'h0;
            end
          end else if (fmt_ff == FMT_3BIT && serial) begin
            emit = 1'b1;
            emit_px = dhp_x111(ev_word[5:3]);
            nxt_pend = dhp_x111(ev_word[2:0]);
            nxt_pend_vld = 1'b1;
          end else if (fmt_ff == FMT_666) begin
            case (phase_ff)
              2'h0: begin
                nxt_hold = {c_lo, hold_ff[CMP_W-1:0]};
                nxt_phase = 2'h1;
              end
              2'h1: begin
                nxt_hold = {hold_ff[CMP_W +: CMP_W], c_lo};
                nxt_phase = 2'h2;
              end
              default: begin
                emit = 1'b1;
                emit_px = {hold_ff, c_lo};
                nxt_phase = 2'h0;
              end
            endcase
          end
        end
        default: begin
          emit = 1'b0;
        end
      endcase
    end
  end

  // packing state; the second serial 3-bit pixel leaves one cycle later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= '0;
      hold_ff <= '0;
      pend_ff <= '0;
      pend_vld_ff <= 1'b0;
      pixel_valid <= 1'b0;
      pixel_rgb <= '0;
    end else begin
      phase_ff <= nxt_phase;
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      pend_vld_ff <= nxt_pend_vld;
      pixel_valid <= emit || pend_vld_ff;
      if (emit) begin
        pixel_rgb <= emit_px;
      end else if (pend_vld_ff) begin
        pixel_rgb <= pend_ff;
      end
    end
  end

  // ==========================================
  // read-back drive; the serial link has no read path here
  logic rd_act;
  assign rd_act = cs_act && !lvl_ff[I_RD] && !serial && !rst_pin;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus.dev_db_oe_n <= 1'b1;
      bus.dev_db_o <= '0;
      rd_start <= 1'b0;
    end else begin
      bus.dev_db_oe_n <= !rd_act;
      rd_start <= rd_act && bus.dev_db_oe_n;
      if (rd_act) begin
        bus.dev_db_o <= rd_data;
      end
    end
  end

  // status outputs
  assign pixel_format = fmt_ff;
  assign bus_mode = mode_ff;
endmodule

/* File: hw/dhp_host_end.sv */
// host end: drives straps, reset pin, strobes, data lines and serial frames
`timescale 1ns/1ps
module dhp_host_end
  import dhp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  dhp_bus_if.host bus,
  input wire logic [2:0] mode_sel,
  input wire logic reset_req,
  input wire logic req_valid,
  input wire logic req_dc,
  input wire logic req_read,
  input wire logic [BUS_W-1:0] req_word,
  input wire logic keep_select,
  output logic req_ready,
  output logic rd_valid,
  output logic [BUS_W-1:0] rd_word
);
  // ==========================================
  // read-back sampling through three stages
  logic [BUS_W-1:0] d1_ff;
  logic [BUS_W-1:0] d2_ff;
  logic [BUS_W-1:0] d3_ff;
  logic [BUS_W-1:0] dl_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      d1_ff <= '1;
      d2_ff <= '1;
      d3_ff <= '1;
      dl_ff <= '1;
    end else begin
      d1_ff <= bus.db;
      d2_ff <= d1_ff;
      d3_ff <= d2_ff;
      dl_ff <= ((d2_ff ~^ d3_ff) & d2_ff) | ((d2_ff ^ d3_ff) & dl_ff);
    end
  end

  // ==========================================
  // straps and panel reset pulse
  logic [CNT_W-1:0] rcnt_ff;
  logic serial;
  assign serial = (bus.interface_mode_straps == MODE_SERIAL);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus.interface_mode_straps <= MODE_BUS18;
      bus.panel_reset_n <= 1'b0;
      rcnt_ff <= CNT_W'(RST_CYC);
    end else begin
      bus.interface_mode_straps <= mode_sel;
      if (reset_req) begin
        rcnt_ff <= CNT_W'(RST_CYC);
        bus.panel_reset_n <= 1'b0;
      end else if (rcnt_ff != '0) begin
        rcnt_ff <= rcnt_ff - 1'b1;
      end else begin
        bus.panel_reset_n <= 1'b1;
      end
    end
  end

  // ==========================================
  // transfer sequencer: setup, strobe low, strobe high with hold
  dhp_hstate_t st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] bits_ff;
  logic [7:0] sh_ff;
  logic rd_op_ff;
  logic busy_ok;
  assign busy_ok = bus.panel_reset_n && rcnt_ff == '0 && !reset_req;

  // data lines stay driven through the hold so the display samples them late
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      bits_ff <= '0;
      sh_ff <= '0;
      rd_op_ff <= 1'b0;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_word <= '0;
      bus.cs_n <= 1'b1;
      bus.dc <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.sda <= 1'b1;
      bus.host_db_o <= '0;
      bus.host_db_oe_n <= 1'b1;
    end else begin
      rd_valid <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          req_ready <= busy_ok;
          if (req_valid && req_ready && busy_ok) begin
            req_ready <= 1'b0;
            bus.cs_n <= 1'b0;
            bus.dc <= req_dc;
            rd_op_ff <= req_read && !serial;
            bits_ff <= 4'(FRAME_BITS);
            sh_ff <= req_word[7:0];
            bus.sda <= req_dc;
            bus.host_db_o <= req_word;
            bus.host_db_oe_n <= req_read || serial;
            cnt_ff <= CNT_W'(SETUP_CYC - 1);
            st_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (rd_op_ff) begin
            bus.read_strobe_n <= 1'b0;
            cnt_ff <= CNT_W'(RD_LOW_CYC - 1);
            st_ff <= ST_LOW;
          end else begin
            bus.write_strobe_n <= 1'b0;
            cnt_ff <= serial ? CNT_W'(SCL_HALF_CYC - 1) : CNT_W'(WR_LOW_CYC - 1);
            st_ff <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            bus.write_strobe_n <= 1'b1;
            bus.read_strobe_n <= 1'b1;
            if (rd_op_ff) begin
              rd_valid <= 1'b1;
              rd_word <= dl_ff;
            end
            bits_ff <= bits_ff - 4'h1;
            cnt_ff <= serial ? CNT_W'(SCL_HALF_CYC - 1) : CNT_W'(HOLD_CYC - 1);
            st_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (serial && bits_ff != '0) begin
            bus.sda <= sh_ff[7];
            sh_ff <= {sh_ff[6:0], 1'b0};
            bus.write_strobe_n <= 1'b0;
            cnt_ff <= CNT_W'(SCL_HALF_CYC - 1);
            st_ff <= ST_LOW;
          end else begin
            bus.host_db_oe_n <= 1'b1;
            bus.cs_n <= !keep_select;
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: dv/dhp_chk.sv */
// concurrent checks on the pins between host end and display end
`timescale 1ns/1ps
module dhp_chk
  import dhp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] interface_mode_straps,
  input wire logic panel_reset_n,
  input wire logic cs_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [BUS_W-1:0] host_db_o,
  input wire logic host_db_oe_n,
  input wire logic dev_db_oe_n
);
  // ==========================================
  // pin protocol
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // both ends driving at once would short the data lines
  a_no_dual_drive: assert property (!(!host_db_oe_n && !dev_db_oe_n))
    else $error("host and display drive the data lines together");
  a_dev_drive_read: assert property ($fell(dev_db_oe_n) |-> !read_strobe_n && !cs_n)
    else $error("display drives data lines without a selected read");
  a_dev_release: assert property ($rose(read_strobe_n) |-> ##[1:8] dev_db_oe_n)
    else $error("display keeps driving after read strobe release");
  a_write_selected: assert property ($fell(write_strobe_n) |-> !cs_n)
    else $error("write strobe falls with chip select high");
  a_wr_low_len: assert property ($fell(write_strobe_n) && interface_mode_straps != MODE_SERIAL
    |-> !write_strobe_n [*5] ##1 write_strobe_n)
    else $error("parallel write strobe low time wrong");
  a_scl_low_len: assert property ($fell(write_strobe_n) && interface_mode_straps == MODE_SERIAL
    |-> !write_strobe_n [*6] ##1 write_strobe_n)
    else $error("serial clock low time wrong");
  // data must not move while the parallel write strobe is low
  a_data_stable: assert property (!write_strobe_n && interface_mode_straps != MODE_SERIAL
    |-> $stable(host_db_o) && !host_db_oe_n)
    else $error("write data not held under write strobe");
  a_straps_fixed: assert property (panel_reset_n && $past(panel_reset_n)
    |-> $stable(interface_mode_straps))
    else $error("straps change outside panel reset");
  // ==========================================
  // scenario coverage
  c_serial_bit: cover property ($fell(write_strobe_n) && interface_mode_straps == MODE_SERIAL);
  c_read_done: cover property ($rose(dev_db_oe_n));
  c_panel_reset: cover property ($fell(panel_reset_n));
endmodule

/* File: dv/testbench.sv */
// self-checking bench joining the host end to the display end
`timescale 1ns/1ps
module testbench;
  import dhp_pkg::*;
  typedef struct {logic [2:0] m; logic [2:0] f; int n; logic [17:0] w [3]; int np; logic [17:0] p [2];} dhp_row_t;
  logic clock, nrst, reset_req, req_valid, req_dc, req_read, keep_select;
  logic [2:0] mode_sel;
  logic [BUS_W-1:0] req_word, rd_data;
  logic req_ready, rd_valid, rd_start, cmd_valid, param_valid, pixel_valid;
  logic [BUS_W-1:0] rd_word, pixel_rgb, rd_seen;
  logic [7:0] cmd_code, param_byte;
  // last command and parameter bytes seen, and read-drive starts counted
  logic [7:0] cmd_seen = 8'h0;
  logic [7:0] param_seen = 8'h0;
  int rd_starts = 0;
  logic [2:0] pixel_format, bus_mode;
  int miscompares = 0;
  int total_checks = 0;
  logic [BUS_W-1:0] pix_q [$];
  dhp_row_t rows [7];
  dhp_bus_if bus ();
  dhp_host_end dhp_host_end_i (.clock(clock), .nrst(nrst), .bus(bus), .mode_sel(mode_sel), .reset_req(reset_req),
    .req_valid(req_valid), .req_dc(req_dc), .req_read(req_read), .req_word(req_word), .keep_select(keep_select),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_word(rd_word));
  dhp_display_end dhp_display_end_i (.clock(clock), .nrst(nrst), .bus(bus), .rd_data(rd_data), .rd_start(rd_start),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_valid(param_valid), .param_byte(param_byte),
    .pixel_valid(pixel_valid), .pixel_rgb(pixel_rgb), .pixel_format(pixel_format), .bus_mode(bus_mode));
  dhp_chk dhp_chk_i (.clock(clock), .nrst(nrst), .interface_mode_straps(bus.interface_mode_straps),
    .panel_reset_n(bus.panel_reset_n), .cs_n(bus.cs_n), .write_strobe_n(bus.write_strobe_n),
    .read_strobe_n(bus.read_strobe_n), .host_db_o(bus.host_db_o), .host_db_oe_n(bus.host_db_oe_n),
    .dev_db_oe_n(bus.dev_db_oe_n));
  // ==========================================
  // clock and output capture
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // pulses are one cycle, so the falling edge sees each exactly once
  always @(negedge clock) begin
    if (pixel_valid === 1'b1) pix_q.push_back(pixel_rgb);
    if (rd_valid === 1'b1) rd_seen = rd_word;
    if (cmd_valid === 1'b1) cmd_seen = cmd_code;
    if (param_valid === 1'b1) param_seen = param_byte;
    if (rd_start === 1'b1) rd_starts++;
  end
  // ==========================================
  // shared tasks
  task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) check(18'h0, 18'h1, "host never ready");
  endtask
  // one request, taken at the edge after it is raised since ready is high
  task automatic xfer(input logic dc, input logic rd, input logic [BUS_W-1:0] w, input logic k);
    wait_ready();
    @(posedge clock);
    req_valid <= 1'b1;
    req_dc <= dc;
    req_read <= rd;
    req_word <= w;
    keep_select <= k;
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    wait_ready();
  endtask
  // straps only move while the panel is held in reset
  task automatic setmode(input logic [2:0] m);
    @(posedge clock);
    reset_req <= 1'b1;
    repeat (3) @(posedge clock);
    mode_sel <= m;
    repeat (3) @(posedge clock);
    reset_req <= 1'b0;
    wait_ready();
    pix_q.delete();
  endtask
  task automatic start_pixels(input logic [2:0] f);
    xfer(1'b0, 1'b0, 18'h3a, 1'b0);
    xfer(1'b1, 1'b0, {15'h0, f}, 1'b0);
    xfer(1'b0, 1'b0, 18'h2c, 1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog: the run needs about 12000 cycles
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    conclude();
  end
  // ==========================================
  // main sequence
  initial begin
    nrst = 1'b0;
    reset_req = 1'b0;
    req_valid = 1'b0;
    req_dc = 1'b1;
    req_read = 1'b0;
    keep_select = 1'b0;
    mode_sel = MODE_BUS18;
    req_word = 18'h0;
    rd_data = 18'h1a5a5;
    rd_seen = 18'h0;
    rows[0] = '{MODE_BUS18, FMT_666, 1, '{18'h212bf, 18'h0, 18'h0}, 1, '{18'h212bf, 18'h0}};
    rows[1] = '{MODE_BUS16, FMT_565, 1, '{18'h0ae6d, 18'h0, 18'h0}, 1, '{18'h2bcda, 18'h0}};
    rows[2] = '{MODE_BUS16, FMT_666, 3, '{18'h08428, 18'h0fc54, 18'h0b81c}, 2, '{18'h212bf, 18'h15b87}};
    rows[3] = '{MODE_BUS8, FMT_565, 2, '{18'h000ae, 18'h0006d, 18'h0}, 1, '{18'h2bcda, 18'h0}};
    rows[4] = '{MODE_BUS8, FMT_666, 3, '{18'h00084, 18'h00028, 18'h000fc}, 1, '{18'h212bf, 18'h0}};
    rows[5] = '{MODE_SERIAL, FMT_666, 3, '{18'h00084, 18'h00028, 18'h000fc}, 1, '{18'h212bf, 18'h0}};
    rows[6] = '{MODE_SERIAL, FMT_3BIT, 1, '{18'h0002b, 18'h0, 18'h0}, 2, '{18'h3f03f, 18'h00fff}};
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    wait_ready();
    check({15'h0, pixel_format}, {15'h0, FMT_RESET}, "format after reset");
    $display("reset test done");
    // every strap code with each of its formats
    foreach (rows[i]) begin
      setmode(rows[i].m);
      start_pixels(rows[i].f);
      for (int j = 0; j < rows[i].n; j++) xfer(1'b1, 1'b0, rows[i].w[j], j < rows[i].n - 1);
      repeat (20) @(negedge clock);
      check({15'h0, bus_mode}, {15'h0, rows[i].m}, "bus mode");
      check({15'h0, pixel_format}, {15'h0, rows[i].f}, "format");
      check({10'h0, cmd_seen}, {10'h0, CMD_MEM_WR}, "last command");
      check({10'h0, param_seen}, {15'h0, rows[i].f}, "format parameter");
      check(18'(pix_q.size()), 18'(rows[i].np), "pixel count");
      for (int j = 0; j < rows[i].np && j < pix_q.size(); j++) begin
        check(pix_q[j], rows[i].p[j], "pixel value");
      end
      $display("row %0d done", i);
    end
    // deselect in mid-pixel drops the two bytes already sent
    setmode(MODE_BUS8);
    start_pixels(FMT_666);
    xfer(1'b1, 1'b0, 18'h00084, 1'b1);
    xfer(1'b1, 1'b0, 18'h00028, 1'b0);
    xfer(1'b1, 1'b0, 18'h00084, 1'b1);
    xfer(1'b1, 1'b0, 18'h00028, 1'b1);
    xfer(1'b1, 1'b0, 18'h000fc, 1'b0);
    repeat (20) @(negedge clock);
    check(18'(pix_q.size()), 18'h1, "pixels after deselect");
    if (pix_q.size() > 0) check(pix_q[0], 18'h212bf, "pixel after deselect");
    $display("deselect test done");
    // 18-bit bus refuses 5-6-5, and data after a format command is no pixel
    setmode(MODE_BUS18);
    start_pixels(FMT_565);
    xfer(1'b1, 1'b0, 18'h212bf, 1'b0);
    xfer(1'b0, 1'b0, 18'h3a, 1'b0);
    xfer(1'b1, 1'b0, {15'h0, FMT_666}, 1'b0);
    xfer(1'b1, 1'b0, 18'h212bf, 1'b0);
    repeat (20) @(negedge clock);
    check(18'(pix_q.size()), 18'h0, "refused pixels");
    $display("refusal test done");
    // read word comes back from the display over the shared lines
    xfer(1'b1, 1'b1, 18'h0, 1'b0);
    repeat (10) @(negedge clock);
    check(rd_seen, 18'h1a5a5, "read word");
    check(18'(rd_starts), 18'h1, "read drive starts");
    $display("read test done");
    conclude();
  end
endmodule
